//--- rtl/icmt_carrier_gen.sv
/*
 * Carrier generator: alternating high and low phases counted in pclk cycles.
 * Phase lengths may change within a period; a shortened live phase ends at once.
 */
module icmt_carrier_gen
	import icmt_pkg::*;
(
	input  wire logic  pclk,
	input  wire logic  presetn,
	icmt_carrier_if.gen car
);

	logic       high_ff;
	logic [7:0] cnt_ff;
	logic       tick_ff;
	logic [7:0] len;

	// A zero byte still gives one clock, so the carrier never stalls
	assign len = car.high_time == 8'h00 && high_ff ? 8'h01 :
		car.low_time == 8'h00 && !high_ff ? 8'h01 :
		high_ff ? car.high_time : car.low_time;

	// ============================================================
	// Phase sequencing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			high_ff <= 1'b1;
			cnt_ff  <= 8'h00;
			tick_ff <= 1'b0;
		end
		else if (car.restart || !car.run)
		begin
			high_ff <= 1'b1;
			cnt_ff  <= 8'h00;
			tick_ff <= 1'b0;
		end
		else if (cnt_ff >= len - 8'h01) // Shortened live phase ends at once, no 256-clock stall
		begin
			high_ff <= !high_ff;
			cnt_ff  <= 8'h00;
			tick_ff <= !high_ff; // End of low phase closes a cycle
		end
		else
		begin
			cnt_ff  <= cnt_ff + 8'h01;
			tick_ff <= 1'b0;
		end
	end

	assign car.level = high_ff;
	assign car.tick  = tick_ff;

	// ============================================================
	// Checks
	a_restart_high:
	assert property (@(posedge pclk) disable iff (!presetn)
		car.restart |=> high_ff && cnt_ff == 8'h00)
	else $error("carrier did not restart in high phase");

endmodule : icmt_carrier_gen

//--- rtl/icmt_carrier_if.sv
/*
 * Link between the timer control logic and its carrier generator.
 * Assumes both ends run on the same pclk.
 */
interface icmt_carrier_if;
	logic       restart;   // Start again at a high phase
	logic       run;       // Generator active
	logic [7:0] high_time; // High phase length in clocks
	logic [7:0] low_time;  // Low phase length in clocks
	logic       level;     // Carrier waveform
	logic       tick;      // One pulse per full carrier cycle

	modport gen (input restart, input run, input high_time, input low_time,
		output level, output tick);
	modport ctl (output restart, output run, output high_time, output low_time,
		input level, input tick);
endinterface : icmt_carrier_if

//--- rtl/icmt_pkg.sv
/*
 * Shared constants for the infrared carrier modulator timer: register map,
 * field positions, reset values and the operating state type.
 * Assumes a 32-bit APB with word-aligned registers.
 */
package icmt_pkg;

	// ============================================================
	// Register byte offsets
	localparam logic [7:0] ICMT_OFS_CTRL    = 8'h00;
	localparam logic [7:0] ICMT_OFS_CARRIER = 8'h04;
	localparam logic [7:0] ICMT_OFS_MODTIME = 8'h08;
	localparam logic [7:0] ICMT_OFS_COUNTER = 8'h0c;
	localparam logic [7:0] ICMT_OFS_STATUS  = 8'h10;
	localparam logic [7:0] ICMT_OFS_MASK    = 8'h14;
	localparam logic [7:0] ICMT_OFS_PWR     = 8'h18;
	localparam logic [7:0] ICMT_OFS_CAPTURE = 8'h1c;

	// ============================================================
	// Control register fields
	localparam int ICMT_CTRL_EN     = 0;
	localparam int ICMT_CTRL_MODE   = 1;
	localparam int ICMT_CTRL_POL    = 2;
	localparam int ICMT_CTRL_DATA   = 3;
	localparam int ICMT_CTRL_RELOAD = 4;
	localparam int ICMT_CTRL_RISE   = 5;
	localparam int ICMT_CTRL_FALL   = 6;
	localparam int ICMT_CTRL_W      = 7;

	// ============================================================
	// Status / mask fields, power control fields
	localparam int ICMT_ST_INTERVAL = 0;
	localparam int ICMT_ST_OVF      = 1;
	localparam int ICMT_ST_W        = 2;
	localparam int ICMT_ST_ACTIVE   = 2;
	localparam int ICMT_ST_PIN      = 3;
	localparam int ICMT_PWR_LEVEL   = 0;
	localparam int ICMT_PWR_OE      = 1;

	// ============================================================
	// Reset values and counter maximum
	localparam logic [ICMT_CTRL_W-1:0] ICMT_CTRL_RST    = 7'h00;
	localparam logic [15:0]            ICMT_CARRIER_RST = 16'h0000;
	localparam logic [15:0]            ICMT_MODTIME_RST = 16'h0000;
	localparam logic [15:0]            ICMT_COUNTER_RST = 16'h0000;
	localparam logic [1:0]             ICMT_PWR_RST     = 2'h0;
	localparam logic [15:0]            ICMT_COUNT_MAX   = 16'hffff;

	// Operating state
	typedef enum logic [1:0] {
		ICMT_IDLE,
		ICMT_TX,
		ICMT_RX
	} icmt_state_e;

endpackage : icmt_pkg

//--- rtl/icmt_top.sv
/*
 * Infrared carrier modulator timer with APB register access.
 * Drives the infrared output pin with a gated carrier in transmit mode and
 * times the infrared input pin in receive mode.
 * Assumes a single 100 MHz pclk, asynchronous active-low presetn, and an
 * input pin that is asynchronous to pclk.
 */
// Added by the designer: register access over APB and the register offsets.
module icmt_top
	import icmt_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        infrared_input_pin,
	output logic             infrared_output_pin,
	output logic             infrared_output_pin_oe,
	output logic             irq
);

	// ============================================================
	// Registers and internal state
	logic [ICMT_CTRL_W-1:0] ctrl_ff;
	logic [15:0]            carrier_period_register_ff;
	logic [15:0]            modulation_interval_register_ff;
	logic [15:0]            interval_counter_ff;
	logic [15:0]            capture_ff;
	logic [ICMT_ST_W-1:0]   status_ff;
	logic [ICMT_ST_W-1:0]   mask_ff;
	logic [1:0]             power_control_register_ff;
	logic [31:0]            prdata_ff;
	logic                   pslverr_ff;
	icmt_state_e            state_ff;
	icmt_state_e            nxt_state;
	logic [15:0]            mt_s_ff;
	logic [15:0]            ca_s_ff;
	logic                   data_s_ff;
	logic                   pol_s_ff;
	logic                   pin_ff;
	logic                   oe_ff;
	logic                   rx_s1_ff;
	logic                   rx_s2_ff;
	logic                   rx_s3_ff;

	logic wr;
	logic rd_setup;
	logic hit;
	logic tx_start;
	logic rx_start;
	logic reload;
	logic capture;
	logic overflow;
	logic cnt_wr;
	logic [ICMT_ST_W-1:0] st_set;
	logic [31:0] rd_mux;

	icmt_carrier_if car ();

	// ============================================================
	// APB slave: zero wait states, data registered in the setup cycle
	assign wr       = psel && penable && pwrite;
	assign rd_setup = psel && !penable;
	assign pready   = 1'b1;
	assign prdata   = prdata_ff;
	assign pslverr  = pslverr_ff;

	// Address decode and read mux
	always_comb
	begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			ICMT_OFS_CTRL:    rd_mux = {25'h0, ctrl_ff};
			ICMT_OFS_CARRIER: rd_mux = {16'h0, carrier_period_register_ff};
			ICMT_OFS_MODTIME: rd_mux = {16'h0, modulation_interval_register_ff};
			ICMT_OFS_COUNTER: rd_mux = {16'h0, interval_counter_ff};
			ICMT_OFS_STATUS:  rd_mux = {28'h0, pin_ff, state_ff == ICMT_TX, status_ff};
			ICMT_OFS_MASK:    rd_mux = {30'h0, mask_ff};
			ICMT_OFS_PWR:     rd_mux = {30'h0, power_control_register_ff};
			ICMT_OFS_CAPTURE: rd_mux = {16'h0, capture_ff};
			default:          hit = 1'b0;
		endcase
	end

	// Read data and error flag, captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end
		else if (rd_setup)
		begin
			prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_ff <= !hit;
		end
	end

	// Software-written configuration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff                         <= ICMT_CTRL_RST;
			carrier_period_register_ff      <= ICMT_CARRIER_RST;
			modulation_interval_register_ff <= ICMT_MODTIME_RST;
			mask_ff                         <= '0;
			power_control_register_ff       <= ICMT_PWR_RST;
		end
		else if (wr)
		begin
			case (paddr)
				ICMT_OFS_CTRL:    ctrl_ff <= pwdata[ICMT_CTRL_W-1:0];
				ICMT_OFS_CARRIER: carrier_period_register_ff <= pwdata[15:0];
				ICMT_OFS_MODTIME: modulation_interval_register_ff <= pwdata[15:0];
				ICMT_OFS_MASK:    mask_ff <= pwdata[ICMT_ST_W-1:0];
				ICMT_OFS_PWR:     power_control_register_ff <= pwdata[1:0];
				default:          ;
			endcase
		end
	end

	// ============================================================
	// Operating state: enable gates everything, mode picks direction
	always_comb
	begin
		if (!ctrl_ff[ICMT_CTRL_EN])
			nxt_state = ICMT_IDLE;
		else if (ctrl_ff[ICMT_CTRL_MODE])
			nxt_state = ICMT_TX;
		else
			nxt_state = ICMT_RX;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_ff <= ICMT_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Either order of enable and mode, or both at once, gives one start
	assign tx_start = nxt_state == ICMT_TX && state_ff != ICMT_TX;
	assign rx_start = nxt_state == ICMT_RX && state_ff != ICMT_RX;

	// ============================================================
	// Carrier generator, fed from the sampled copy while transmitting
	assign car.restart   = tx_start || rx_start;
	assign car.run       = state_ff != ICMT_IDLE;
	assign car.high_time = state_ff == ICMT_TX ? ca_s_ff[15:8]
		: carrier_period_register_ff[15:8];
	assign car.low_time  = state_ff == ICMT_TX ? ca_s_ff[7:0]
		: carrier_period_register_ff[7:0];

	icmt_carrier_gen u_carrier (
		.pclk    (pclk),
		.presetn (presetn),
		.car     (car)
	);

	// ============================================================
	// Input pin synchroniser; third stage only feeds the edge detector
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_s1_ff <= 1'b1;
			rx_s2_ff <= 1'b1;
			rx_s3_ff <= 1'b1;
		end
		else
		begin
			rx_s1_ff <= infrared_input_pin;
			rx_s2_ff <= rx_s1_ff;
			rx_s3_ff <= rx_s2_ff;
		end
	end

	assign capture = state_ff == ICMT_RX &&
		((ctrl_ff[ICMT_CTRL_RISE] && rx_s2_ff && !rx_s3_ff) ||
		(ctrl_ff[ICMT_CTRL_FALL] && !rx_s2_ff && rx_s3_ff));

	// ============================================================
	// Interval counter
	assign reload   = state_ff == ICMT_TX && !tx_start && car.tick &&
		interval_counter_ff == 16'h0000;
	// Flag only a real wrap: a load, a preset or a clearing capture wins over the step
	assign overflow = state_ff == ICMT_RX && !tx_start && !cnt_wr &&
		!(capture && ctrl_ff[ICMT_CTRL_RELOAD]) && car.tick &&
		interval_counter_ff == ICMT_COUNT_MAX;
	// Software may preset the counter outside transmit only
	assign cnt_wr   = wr && paddr == ICMT_OFS_COUNTER && state_ff != ICMT_TX;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			interval_counter_ff <= ICMT_COUNTER_RST;
		else if (tx_start || reload)
			interval_counter_ff <= modulation_interval_register_ff;
		else if (state_ff == ICMT_TX && car.tick)
			interval_counter_ff <= interval_counter_ff - 16'h0001;
		else if (cnt_wr)
			interval_counter_ff <= pwdata[15:0];
		else if (capture && ctrl_ff[ICMT_CTRL_RELOAD])
			interval_counter_ff <= 16'h0000;
		else if (state_ff == ICMT_RX && car.tick)
			interval_counter_ff <= interval_counter_ff + 16'h0001;
	end

	// Capture value for software, taken before any clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			capture_ff <= 16'h0000;
		else if (capture)
			capture_ff <= interval_counter_ff;
	end

	// ============================================================
	// Sampled settings: held for a whole interval
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mt_s_ff   <= ICMT_MODTIME_RST;
			ca_s_ff   <= ICMT_CARRIER_RST;
			data_s_ff <= 1'b0;
			pol_s_ff  <= 1'b0;
		end
		else if (tx_start || reload)
		begin
			mt_s_ff   <= modulation_interval_register_ff;
			ca_s_ff   <= carrier_period_register_ff;
			data_s_ff <= ctrl_ff[ICMT_CTRL_DATA];
			pol_s_ff  <= ctrl_ff[ICMT_CTRL_POL];
		end
	end

	// ============================================================
	// Output pin, registered so the pad never glitches
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_ff <= 1'b0;
			oe_ff  <= 1'b0;
		end
		else
		begin
			case (state_ff)
				ICMT_IDLE:
				begin
					pin_ff <= power_control_register_ff[ICMT_PWR_LEVEL];
					oe_ff  <= power_control_register_ff[ICMT_PWR_OE];
				end
				ICMT_TX:
				begin
					pin_ff <= data_s_ff ? (car.level ^ pol_s_ff) : pol_s_ff;
					oe_ff  <= 1'b1;
				end
				ICMT_RX:
				begin
					pin_ff <= ctrl_ff[ICMT_CTRL_POL];
					oe_ff  <= 1'b1;
				end
				default:
				begin
					pin_ff <= 1'b0;
					oe_ff  <= 1'b0;
				end
			endcase
		end
	end

	assign infrared_output_pin    = pin_ff;
	assign infrared_output_pin_oe = oe_ff;

	// ============================================================
	// Sticky status, write one to clear; a new event beats the clear
	assign st_set = {overflow, reload};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_ff <= '0;
		else if (wr && paddr == ICMT_OFS_STATUS)
			status_ff <= (status_ff & ~pwdata[ICMT_ST_W-1:0]) | st_set;
		else
			status_ff <= status_ff | st_set;
	end

	// Level interrupt from unmasked status
	assign irq = |(status_ff & mask_ff);

	// ============================================================
	// Checks
	a_manual_pin:
	assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ICMT_IDLE |=> infrared_output_pin_oe ==
		$past(power_control_register_ff[ICMT_PWR_OE]))
	else $error("manual drive enable not followed");

	a_tx_load:
	assert property (@(posedge pclk) disable iff (!presetn)
		tx_start |=> interval_counter_ff == $past(modulation_interval_register_ff)
		&& state_ff == ICMT_TX)
	else $error("counter not loaded at transmit start");

	a_tx_down:
	assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ICMT_TX && nxt_state == ICMT_TX && car.tick &&
		interval_counter_ff != 16'h0000 |=>
		interval_counter_ff == $past(interval_counter_ff) - 16'h0001)
	else $error("transmit counter did not step down");

	a_rx_up:
	assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ICMT_RX && !tx_start && car.tick && !capture && !cnt_wr |=>
		interval_counter_ff == $past(interval_counter_ff) + 16'h0001)
	else $error("receive counter did not step up");

	a_rx_clear:
	assert property (@(posedge pclk) disable iff (!presetn)
		capture && ctrl_ff[ICMT_CTRL_RELOAD] && !cnt_wr && !tx_start |=>
		interval_counter_ff == 16'h0000)
	else $error("counter not cleared on capture");

	a_ovf_flag:
	assert property (@(posedge pclk) disable iff (!presetn)
		overflow |=> status_ff[ICMT_ST_OVF] && interval_counter_ff == 16'h0000)
	else $error("overflow flag not set on wrap");

	a_reload_flag:
	assert property (@(posedge pclk) disable iff (!presetn)
		reload |=> status_ff[ICMT_ST_INTERVAL] && mt_s_ff == interval_counter_ff)
	else $error("reload did not set flag and resample");

	a_idle_level:
	assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ICMT_TX && !data_s_ff |=> infrared_output_pin == $past(pol_s_ff))
	else $error("idle level wrong for data zero");

	a_hold_sample:
	assert property (@(posedge pclk) disable iff (!presetn)
		!tx_start && !reload |=> $stable(ca_s_ff) && $stable(data_s_ff) &&
		$stable(pol_s_ff) && $stable(mt_s_ff))
	else $error("sampled settings changed mid interval");

	a_stop_tx:
	assert property (@(posedge pclk) disable iff (!presetn)
		!(ctrl_ff[ICMT_CTRL_EN] && ctrl_ff[ICMT_CTRL_MODE]) |=> state_ff != ICMT_TX)
	else $error("transmit did not stop");

endmodule : icmt_top

//--- test/icmt_ir_partner.sv
/*
 * Far-side model: an infrared emitter lit by the output pin and a receiver
 * module whose open-collector output idles high.
 * Assumes it shares pclk and presetn with the timer.
 */
module icmt_ir_partner
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        drive_level,
	input  wire logic        drive_oe,
	input  wire logic        mark,
	output logic             rx_level,
	output logic      [31:0] light_count
);
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// Emitter
	// Counts lit clocks; an undriven pin leaves the diode dark
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			light_count <= '0;
		else if (drive_oe && drive_level)
			light_count <= light_count + 32'h1;

	// ============================================================
	// Receiver
	// Pulled low while a burst is seen, pull-up holds it high otherwise
	assign rx_level = ~mark;
endmodule : icmt_ir_partner

//--- test/icmt_top_tb.sv
/*
 * Self-checking bench for the infrared timer: APB master, scenarios, verdict.
 * Assumes the partner model on the pins and a 100 MHz pclk.
 */
module icmt_top_tb
	import icmt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CH = 2;
	localparam int CL = 1;
	localparam int MT0 = 4;
	localparam int MT1 = 7;
	logic        pclk, presetn, psel, penable, pwrite, mark;
	logic        pready, pslverr, rx_pin, tx_pin, tx_oe, irq, rd_err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, light, rd_val;
	int          err_count, checks_done, t_prev, l_prev;
	int          cyc = 0;

	icmt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .infrared_input_pin(rx_pin),
		.infrared_output_pin(tx_pin), .infrared_output_pin_oe(tx_oe), .irq(irq));
	icmt_ir_partner ir (.pclk(pclk), .presetn(presetn), .drive_level(tx_pin),
		.drive_oe(tx_oe), .mark(mark), .rx_level(rx_pin), .light_count(light));

	// ============================================================
	// Clock and cycle count
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;

	// ============================================================
	// Helpers
	// Tolerance lets the pin lag the flag by a clock at interval edges
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got,
		input int tol = 0);
		checks_done++;
		// An unknown never passes, tolerance or not
		if (^got === 1'bx ||
			(got !== exp && !(tol > 0 && got + tol >= exp && got <= exp + tol)))
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_val = prdata;
		rd_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd

	// Waits for the next interval flag, then clears it
	task automatic step(output int dt, output int dl);
		int n;
		n = 0;
		while (irq !== 1'b0 && n++ < 100) @(posedge pclk);
		while (irq !== 1'b1 && n++ < 200) @(posedge pclk);
		dt = cyc - t_prev;
		dl = light - l_prev;
		t_prev = cyc;
		l_prev = light;
		wr(ICMT_OFS_STATUS, 32'h1);
	endtask : step

	// ============================================================
	// Scenarios
	task automatic t_reset;
		chk("pin oe", 0, {tx_pin, tx_oe});
		rd(ICMT_OFS_CTRL);
		chk("ctrl", 0, rd_val);
		rd(8'h20);
		chk("unmapped err", 1, rd_err);
	endtask : t_reset

	task automatic t_manual;
		logic [1:0] v[3] = '{2'h3, 2'h2, 2'h0};
		for (int i = 0; i < 3; i++)
		begin
			wr(ICMT_OFS_PWR, v[i]);
			repeat (2) @(posedge pclk);
			chk("manual pin", {v[i][1], v[i][0]}, {tx_oe, tx_pin});
		end
	endtask : t_manual

	task automatic t_pol;
		for (int p = 0; p < 2; p++)
		begin
			wr(ICMT_OFS_CTRL, 32'h1 | (p << 2));
			repeat (3) @(posedge pclk);
			chk("idle pin", {1'b1, p[0]}, {tx_oe, tx_pin});
		end
		wr(ICMT_OFS_CTRL, 32'h0);
	endtask : t_pol

	// Start in every order, stop by clearing mode or enable
	task automatic t_start;
		logic [31:0] first[3] = '{32'h2, 32'h1, 32'h3};
		logic [31:0] stop[3] = '{32'h1, 32'h2, 32'h1};
		for (int k = 0; k < 3; k++)
		begin
			wr(ICMT_OFS_CTRL, first[k]);
			wr(ICMT_OFS_CTRL, 32'h3);
			rd(ICMT_OFS_STATUS);
			chk("active", 1, rd_val[2]);
			wr(ICMT_OFS_CTRL, stop[k]);
			rd(ICMT_OFS_STATUS);
			chk("stopped", 0, rd_val[2]);
			wr(ICMT_OFS_CTRL, 32'h0);
		end
	endtask : t_start

	// Settings written mid-interval show only after the next reload
	task automatic t_tx;
		int dt, dl;
		logic [31:0] c[5] = '{32'h3, 32'hf, 32'h7, 32'h7, 32'h7};
		int el[5] = '{(MT0 + 1) * CH, 0, (MT0 + 1) * CL, (MT0 + 1) * (CH + CL),
			(MT1 + 1) * (CH + CL)};
		wr(ICMT_OFS_CARRIER, (CH << 8) | CL);
		wr(ICMT_OFS_MODTIME, MT0);
		wr(ICMT_OFS_STATUS, 32'h3); // Stale flags would skew the first step
		wr(ICMT_OFS_MASK, 32'h1);
		wr(ICMT_OFS_CTRL, 32'hb);
		step(dt, dl);
		for (int i = 0; i < 5; i++)
		begin
			wr(ICMT_OFS_CTRL, c[i]);
			if (i == 3)
				wr(ICMT_OFS_MODTIME, MT1);
			step(dt, dl);
			chk("interval", ((i < 4 ? MT0 : MT1) + 1) * (CH + CL), dt);
			chk("lit clocks", el[i], dl, 1);
		end
		wr(ICMT_OFS_CTRL, 32'h0);
	endtask : t_tx

	task automatic t_ovf;
		wr(ICMT_OFS_MASK, 32'h0);
		wr(ICMT_OFS_CARRIER, 32'h0101);
		wr(ICMT_OFS_COUNTER, 32'hfffe);
		wr(ICMT_OFS_CTRL, 32'h1);
		repeat (12) @(posedge pclk);
		rd(ICMT_OFS_COUNTER);
		chk("count up", 1, rd_val < 32'h10);
		rd(ICMT_OFS_STATUS);
		chk("overflow", 1, rd_val[1]);
		chk("irq masked", 0, irq);
		wr(ICMT_OFS_MASK, 32'h2);
		@(posedge pclk);
		chk("irq on", 1, irq);
		wr(ICMT_OFS_STATUS, 32'h2);
		@(posedge pclk);
		chk("irq off", 0, irq);
	endtask : t_ovf

	// Falling edge captures free-running, rising edge captures with reload
	task automatic t_cap;
		for (int r = 0; r < 2; r++)
		begin
			wr(ICMT_OFS_CTRL, 32'h0);
			mark <= r[0];
			wr(ICMT_OFS_COUNTER, 32'h100);
			wr(ICMT_OFS_CTRL, r ? 32'h31 : 32'h41);
			@(posedge pclk) mark <= !r[0];
			repeat (8) @(posedge pclk);
			rd(ICMT_OFS_CAPTURE);
			chk("capture", 1, rd_val >= 32'h100 && rd_val < 32'h140);
			rd(ICMT_OFS_COUNTER);
			chk("reload", 1, r ? rd_val < 32'h40 : rd_val >= 32'h100);
			@(posedge pclk) mark <= 1'b0;
		end
	endtask : t_cap

	// ============================================================
	// Verdict, main sequence and watchdog
	task print_verdict;
		$display("err_count %0d checks_done %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	initial
	begin
		{presetn, psel, penable, pwrite, mark} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_manual;
		t_pol;
		t_start;
		t_tx;
		t_ovf;
		t_cap;
		print_verdict;
	end

	// Whole run needs about three hundred cycles
	initial
	begin
		#50us;
		err_count++;
		print_verdict;
	end
endmodule : icmt_top_tb
